/* msequence_burst_gen_and_correlator.sv */
/*
 * Pseudo-random burst transmitter and matched-filter correlator.
 * The transmitter sends one full code period per data bit; the receiver
 * oversamples a hard-limited chip stream, correlates it and flags bits.
 * Assumes all inputs are synchronous to clk_i and that the channel
 * delivers one binary chip level on rx_chip_i.
 */
`timescale 1ns/1ps
`default_nettype none

module msequence_burst_gen_and_correlator
   import msequence_pkg::*;
(
   // Clock and reset
   input  wire logic             clk_i,
   input  wire logic             sys_rst_i,
   // Data bits to transmit
   input  wire logic             bit_valid_i,
   input  wire logic             bit_i,
   output var  logic             bit_ready_o,
   // Chip stream towards the channel
   output var  logic             tx_chip_o,
   output var  logic             tx_active_o,
   // Chip stream from the channel and detector setup
   input  wire logic             rx_chip_i,
   input  wire logic             barker_sel_i,
   input  wire logic [THR_W-1:0] threshold_i,
   // Correlator result
   output var  rx_result_s       result_o
);

   ////////////////////////////////////////////////////////////////////////

   typedef struct packed {
      tx_state_e                 st;
      logic [LFSR_N-1:0]         lfsr;
      logic [CNT_W-1:0]          chip_cnt;
      logic                      data_bit;
      logic                      ready;
      logic                      tx_chip;
      logic                      tx_active;
      logic [DIV_W-1:0]          chip_div;
      logic [DIV_W-1:0]          samp_div;
      logic                      phase;
      logic [CODE_LEN-1:0]       rx_sr;
      logic signed [SUM_W-1:0]   sum;
      logic                      detect;
      logic                      rx_bit;
   } core_s;

   core_s                   r_reg;
   core_s                   r_next;
   logic                    chip_tick;
   logic                    samp_tick;
   logic                    shift_in;
   logic                    start;
   logic [THR_W-1:0]        thr_eff;
   logic signed [SUM_W-1:0] thr_pos;
   logic signed [SUM_W-1:0] sum_comb;
   logic signed [SUM_W-1:0] term [CODE_LEN];

   assign chip_tick = (r_reg.chip_div == CHIP_DIV_LAST);
   assign samp_tick = (r_reg.samp_div == SAMPLE_DIV_LAST);
   // Only the second sample of each pair enters the filter. It falls on the
   // last clock of a chip, so the taps stay one chip apart while oversampled.
   assign shift_in  = samp_tick && r_reg.phase;
   assign start     = (r_reg.st == ST_IDLE) && r_reg.ready && bit_valid_i;

   ////////////////////////////////////////////////////////////////////////
   // Tap weights: each stage in use counts +1 on a match and -1 otherwise; stages past the seven-chip pattern count 0 when it is selected.

   for (genvar i = 0; i < CODE_LEN; i++) begin : g_tap
      localparam logic M_WANT = M_CODE[CODE_LEN-1-i];
      localparam logic B_USE  = (i < BARKER_LEN);
      localparam int   B_IDX  = B_USE ? BARKER_LEN - 1 - i : 0;
      localparam logic B_WANT = B_USE ? BARKER_CODE[B_IDX] : 1'b0;
      logic want;
      logic use_tap;
      assign want    = barker_sel_i ? B_WANT : M_WANT;
      assign use_tap = !barker_sel_i || B_USE;
      assign term[i] = !use_tap ? SUM_W'(0)
                     : (r_reg.rx_sr[i] == want) ? SUM_W'(1) : -SUM_W'(1);
   end

   always_comb begin
      sum_comb = '0;
      for (int i = 0; i < CODE_LEN; i++) begin
         sum_comb = sum_comb + term[i];
      end
   end

   // The caller's threshold is raised to the sidelobe floor of the
   // chosen pattern, so a low setting cannot fire on sidelobes.
   always_comb begin
      thr_eff = barker_sel_i ? BARKER_SIDELOBE_MAX : M_SIDELOBE_MAX;
      if (threshold_i > thr_eff) begin
         thr_eff = threshold_i;
      end
      thr_pos = $signed({1'b0, thr_eff});
   end

   ////////////////////////////////////////////////////////////////////////

   always_comb begin
      r_next = r_reg;
      r_next.chip_div = chip_tick ? '0 : r_reg.chip_div + DIV_W'(1);
      r_next.samp_div = samp_tick ? '0 : r_reg.samp_div + DIV_W'(1);

      unique case (r_reg.st)
         ST_IDLE: begin
            if (chip_tick) begin
               r_next.tx_active = 1'b0;
            end
            if (start) begin
               // Re-seeding aligns every burst to the start of the code.
               r_next.st       = ST_BURST;
               r_next.lfsr     = LFSR_SEED;
               r_next.chip_cnt = '0;
               r_next.data_bit = bit_i;
               r_next.ready    = 1'b0;
            end
         end
         ST_BURST: begin
            if (chip_tick) begin
               // A zero bit is sent as the inverted code.
               r_next.tx_chip   = r_reg.lfsr[LFSR_N-1] ^ ~r_reg.data_bit;
               r_next.tx_active = 1'b1;
               r_next.lfsr      = {r_reg.lfsr[LFSR_N-2:0],
                                   r_reg.lfsr[TAP_A-1] ^ r_reg.lfsr[LFSR_N-1]};
               r_next.chip_cnt  = r_reg.chip_cnt + CNT_W'(1);
               if (r_reg.chip_cnt == CHIP_CNT_LAST) begin
                  r_next.st    = ST_IDLE;
                  r_next.ready = 1'b1;
               end
            end
         end
      endcase

      if (samp_tick) begin
         r_next.phase  = ~r_reg.phase;
         r_next.sum    = sum_comb;
         r_next.detect = (sum_comb > thr_pos) || (sum_comb < -thr_pos);
         r_next.rx_bit = (sum_comb > thr_pos);
      end
      if (shift_in) begin
         r_next.rx_sr = {r_reg.rx_sr[CODE_LEN-2:0], rx_chip_i};
      end
   end

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         r_reg           <= '0;
         r_reg.st        <= ST_IDLE;
         r_reg.lfsr      <= LFSR_SEED;
         r_reg.ready     <= 1'b1;
      end else begin
         r_reg <= r_next;
      end
   end

   assign bit_ready_o = r_reg.ready;
   assign tx_chip_o   = r_reg.tx_chip;
   assign tx_active_o = r_reg.tx_active;
   assign result_o    = '{detect: r_reg.detect, bit_value: r_reg.rx_bit, sum: r_reg.sum};

   ////////////////////////////////////////////////////////////////////////
   // Checks.

   // Samples seen since the last chip tick; the one on the tick is added at the check.
   logic [2:0] samp_since_chip;

   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         samp_since_chip <= 3'h0;
      end else if (chip_tick) begin
         samp_since_chip <= 3'h0;
      end else if (samp_tick && samp_since_chip != 3'h7) begin
         samp_since_chip <= samp_since_chip + 3'h1;
      end
   end

   a_seed_nonzero: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      r_reg.lfsr != LFSR_ZERO)
      else $error("generator register reached all zeros");

   a_feedback_xor: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (r_reg.st == ST_BURST && chip_tick) |=>
      r_reg.lfsr[0] == $past(r_reg.lfsr[TAP_A-1] ^ r_reg.lfsr[LFSR_N-1]))
      else $error("first stage did not take the feedback xor");

   a_chip_last_stage: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (r_reg.st == ST_BURST && chip_tick) |=>
      tx_chip_o == $past(r_reg.lfsr[LFSR_N-1] ^ ~r_reg.data_bit) && tx_active_o)
      else $error("sent chip is not the last stage");

   a_period_seed: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      (r_reg.st == ST_BURST && chip_tick && r_reg.chip_cnt == CHIP_CNT_LAST) |=>
      r_reg.lfsr == LFSR_SEED && r_reg.st == ST_IDLE && bit_ready_o)
      else $error("code period is not full length");

   a_burst_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      start |=> r_reg.st == ST_BURST && r_reg.chip_cnt == '0
      && r_reg.data_bit == $past(bit_i) && !bit_ready_o)
      else $error("burst did not start on an accepted bit");

   a_rx_shift: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      shift_in |=> r_reg.rx_sr == {$past(r_reg.rx_sr[CODE_LEN-2:0]), $past(rx_chip_i)})
      else $error("filter register did not shift in the sample");

   a_oversample: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      chip_tick && !$past(chip_tick) |-> ({1'b0, samp_since_chip} + 4'(samp_tick)) >= 4'h2)
      else $error("fewer than two samples per chip");

   a_sum_update: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      samp_tick |=> result_o.sum == $past(sum_comb))
      else $error("sum not taken on the sample");

   a_barker_peak: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      barker_sel_i && r_reg.rx_sr[BARKER_LEN-1:0] == 7'h72 |-> sum_comb == SUM_W'(7))
      else $error("aligned seven-chip pattern did not peak at seven");

   a_detect_thresh: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      samp_tick && (sum_comb <= thr_pos) && (sum_comb >= -thr_pos) |=> !result_o.detect)
      else $error("detection fired at or below threshold");

   ////////////////////////////////////////////////////////////////////////
   // Hold and ordering checks: outputs other than ready move only on their own ticks.

   a_tx_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !chip_tick |=> $stable(tx_chip_o))
      else $error("sent chip changed between chip ticks");

   a_active_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !chip_tick |=> $stable(tx_active_o))
      else $error("burst activity changed between chip ticks");

   a_ready_idle: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      bit_ready_o |-> r_reg.st == ST_IDLE)
      else $error("ready raised during a burst");

   a_idle_lfsr: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      r_reg.st == ST_IDLE && !start |=> r_reg.lfsr == $past(r_reg.lfsr))
      else $error("generator shifted while idle");

   a_chip_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      r_reg.st == ST_BURST |-> r_reg.chip_cnt <= CHIP_CNT_LAST)
      else $error("burst ran past the code period");

   a_ready_rise: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      $rose(bit_ready_o) |-> $past(r_reg.chip_cnt) == CHIP_CNT_LAST)
      else $error("ready returned before the last chip");

   a_reseed_start: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      start |=> r_reg.lfsr == LFSR_SEED)
      else $error("burst did not start from the seed");

   a_active_burst: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      r_reg.st == ST_BURST && r_reg.chip_cnt != '0 |-> tx_active_o)
      else $error("burst chip sent without activity flag");

   a_result_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !samp_tick |=> $stable(result_o))
      else $error("result changed between samples");

   a_rx_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      !shift_in |=> $stable(r_reg.rx_sr))
      else $error("filter register moved without a shift");

   a_shift_spacing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      shift_in |=> !shift_in [*8])
      else $error("filter shifted twice within a chip");

   a_sample_spacing: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      samp_tick |=> !samp_tick [*8])
      else $error("sample ticks too close together");

   a_bit_positive: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      samp_tick && sum_comb > thr_pos |=> result_o.detect && result_o.bit_value)
      else $error("positive peak not reported as a one");

   a_bit_negative: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      samp_tick && sum_comb < -thr_pos |=> result_o.detect && !result_o.bit_value)
      else $error("negative peak not reported as a zero");

   a_thr_floor: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      thr_eff >= threshold_i && thr_eff >= (barker_sel_i ? BARKER_SIDELOBE_MAX : M_SIDELOBE_MAX))
      else $error("threshold below request or sidelobe floor");

   a_barker_trough: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      barker_sel_i && r_reg.rx_sr[BARKER_LEN-1:0] == 7'h0D |-> sum_comb == -SUM_W'(7))
      else $error("inverted seven-chip pattern did not reach minus seven");

   a_sum_range: assert property (@(posedge clk_i) disable iff (sys_rst_i)
      result_o.sum <= SUM_W'(CODE_LEN) && result_o.sum >= -SUM_W'(CODE_LEN))
      else $error("sum outside the filter length");

endmodule // msequence_burst_gen_and_correlator

`default_nettype wire

/* msequence_pkg.sv */
/*
 * Constants, code tables and carrier types for the pseudo-random burst
 * generator and its matched-filter receiver.
 * Assumes a single 20 MHz clock; the divider counts below are in cycles of it.
 */
`default_nettype none

package msequence_pkg;

   // Generator width and feedback: stage LFSR_N xor stage TAP_A.
   localparam int LFSR_N = 5;

   // Second feedback tap for a maximal period at widths 2 to 7.
   function automatic int fb_tap(input int n);
      unique case (n)
         2:       return 1;
         3:       return 2;
         4:       return 3;
         6:       return 5;
         7:       return 6;
         default: return 3;
      endcase
   endfunction

   localparam int TAP_A    = fb_tap(LFSR_N);
   localparam int CODE_LEN = (1 << LFSR_N) - 1;
   localparam int CNT_W    = $clog2(CODE_LEN);
   localparam logic [LFSR_N-1:0] LFSR_SEED = 5'h01;
   localparam logic [LFSR_N-1:0] LFSR_ZERO = 5'h00;

   // Chip k of the code sent from the last stage, starting at the seed.
   function automatic logic [CODE_LEN-1:0] m_code();
      logic [LFSR_N-1:0]   s;
      logic [CODE_LEN-1:0] c;
      s = LFSR_SEED;
      c = '0;
      for (int k = 0; k < CODE_LEN; k++) begin
         c[k] = s[LFSR_N-1];
         s    = {s[LFSR_N-2:0], s[TAP_A-1] ^ s[LFSR_N-1]};
      end
      return c;
   endfunction

   localparam logic [CODE_LEN-1:0] M_CODE = m_code();

   // Seven-chip pattern, first chip in bit 0, a one standing for +1.
   localparam int         BARKER_LEN  = 7;
   localparam logic [6:0] BARKER_CODE = 7'h27;

   // Correlation sum and detection floors above the worst sidelobes.
   localparam int SUM_W = 6;
   localparam int THR_W = SUM_W - 1;
   localparam logic [THR_W-1:0] M_SIDELOBE_MAX      = 5'h07;
   localparam logic [THR_W-1:0] BARKER_SIDELOBE_MAX = 5'h01;

   // Timing.
   localparam int CLK_PERIOD_NS  = 50;
   localparam int CHIP_PERIOD_NS = 1000;
   localparam int RX_OVERSAMPLE  = 2;
   localparam int CHIP_DIV       = CHIP_PERIOD_NS / CLK_PERIOD_NS;
   localparam int SAMPLE_DIV     = CHIP_DIV / RX_OVERSAMPLE;
   localparam int DIV_W          = $clog2(CHIP_DIV);
   localparam logic [DIV_W-1:0] CHIP_DIV_LAST   = DIV_W'(CHIP_DIV - 1);
   localparam logic [DIV_W-1:0] SAMPLE_DIV_LAST = DIV_W'(SAMPLE_DIV - 1);
   localparam logic [CNT_W-1:0] CHIP_CNT_LAST   = CNT_W'(CODE_LEN - 1);

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_BURST = 2'b01
   } tx_state_e;

   typedef struct packed {
      logic                    detect;
      logic                    bit_value;
      logic signed [SUM_W-1:0] sum;
   } rx_result_s;

endpackage

`default_nettype wire

/* msequence_channel.sv */
/*
 * Channel model between the burst transmitter and the correlator.
 * Assumes its controls change only at the falling clock edge.
 */
`timescale 1ns/1ps
`default_nettype none

module msequence_channel (
   // Chip streams
   input  wire logic tx_chip_i,
   output var  logic rx_chip_o,
   // Impairment and injection controls
   input  wire logic invert_i,
   input  wire logic inject_en_i,
   input  wire logic inject_chip_i
);
   // A reversed link flips every chip, so the receiver must report the opposite bit.
   always_comb rx_chip_o = inject_en_i ? inject_chip_i : (tx_chip_i ^ invert_i);
endmodule // msequence_channel

`default_nettype wire

/* tb.sv */
/*
 * Self-checking bench for the burst generator and correlator.
 * Assumes msequence_pkg and the channel model are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
   import msequence_pkg::*;
   logic             clk_i = 1'b0;
   logic             sys_rst_i = 1'b1;
   logic             bit_valid_i = 1'b0;
   logic             bit_i = 1'b0;
   logic             barker_sel_i = 1'b0;
   logic [THR_W-1:0] threshold_i = 5'h00;
   logic             invert = 1'b0;
   logic             inj_en = 1'b0;
   logic             inj_chip = 1'b0;
   logic             chk_en = 1'b0;
   logic             bit_ready_o, tx_chip_o, tx_active_o, rx_chip;
   rx_result_s       result_o;
   logic signed [SUM_W-1:0] prev_sum = '0;
   int               failures = 0;
   int               n_compared = 0;
   int               full_len = CODE_LEN;
   int               peaks[$];

   msequence_burst_gen_and_correlator u_msequence_burst_gen_and_correlator (.clk_i(clk_i),
      .sys_rst_i(sys_rst_i), .bit_valid_i(bit_valid_i), .bit_i(bit_i), .bit_ready_o(bit_ready_o),
      .tx_chip_o(tx_chip_o), .tx_active_o(tx_active_o), .rx_chip_i(rx_chip),
      .barker_sel_i(barker_sel_i), .threshold_i(threshold_i), .result_o(result_o));
   msequence_channel u_msequence_channel (.tx_chip_i(tx_chip_o), .rx_chip_o(rx_chip),
      .invert_i(invert), .inject_en_i(inj_en), .inject_chip_i(inj_chip));

   initial forever #(CLK_PERIOD_NS / 2) clk_i = ~clk_i;

   ////////////////////////////////////////////////////////////////////////////////
   task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, got);
      end
   endtask

   task automatic wrap_up();
      $display("Compared %0d, failures %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   // Reference code: five stages, stage three xor stage five into stage one, chip from stage five.
   function automatic int chip_of(input int k);
      int s;
      s = int'(LFSR_SEED);
      for (int i = 0; i < k; i++) s = ((s << 1) & 31) | (((s >> 2) ^ (s >> 4)) & 1);
      return (s >> 4) & 1;
   endfunction

   // Every settled result is judged against the threshold the model derives.
   always @(negedge clk_i) if (chk_en) begin : judge
      int s, thr;
      s = result_o.sum;
      thr = barker_sel_i ? int'(BARKER_SIDELOBE_MAX) : int'(M_SIDELOBE_MAX);
      if (int'(threshold_i) > thr) thr = threshold_i;
      cmp("detect", {7'h00, 1'(s > thr || -s > thr)}, {7'h00, result_o.detect});
      if (result_o.detect === 1'b1) cmp("bit_value", {7'h00, 1'(s > 0)}, {7'h00, result_o.bit_value});
      if (result_o.sum !== prev_sum && (s == full_len || s == -full_len)) peaks.push_back(s > 0);
      prev_sum = result_o.sum;
   end

   // Bits stay offered with valid held high until ready lets the next edge take them.
   task automatic send(input int b);
      int t;
      t = 0;
      while (bit_ready_o !== 1'b1 && t < 2000) begin
         @(negedge clk_i);
         t++;
      end
      bit_valid_i = 1'b1;
      bit_i = b[0];
      @(negedge clk_i);
   endtask

   task automatic setup(input logic bsel, input int thr_max, input int len);
      chk_en = 1'b0;
      barker_sel_i = bsel;
      threshold_i = 5'($urandom_range(0, thr_max));
      full_len = len;
      peaks.delete();
      repeat (180) @(negedge clk_i);
      chk_en = 1'b1;
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   task automatic run_tx(input int nb, input logic inv);
      int b[4];
      int t;
      invert = inv;
      setup(1'b0, 31, CODE_LEN);
      foreach (b[i]) b[i] = $urandom_range(0, 1);
      fork
         begin
            for (int i = 0; i < nb; i++) send(b[i]);
            bit_valid_i = 1'b0;
         end
         begin
            t = 0;
            while (tx_active_o !== 1'b1 && t < 100) begin
               @(negedge clk_i);
               t++;
            end
            for (int i = 0; i < nb; i++)
               for (int k = 0; k < CODE_LEN; k++) begin
                  repeat (10) @(negedge clk_i);
                  cmp("tx_chip", {7'h00, 1'(chip_of(k) ^ (b[i] == 0))}, {7'h00, tx_chip_o});
                  cmp("tx_active", 8'h01, {7'h00, tx_active_o});
                  repeat (10) @(negedge clk_i);
               end
         end
      join
      repeat (40) @(negedge clk_i);
      cmp("tx_idle", 8'h00, {7'h00, tx_active_o});
      cmp("peak_count", 8'(nb), 8'(peaks.size()));
      foreach (peaks[i]) cmp("peak_sign", 8'(b[i] ^ inv), 8'(peaks[i]));
   endtask

   task automatic run_barker();
      logic [6:0] pat;
      // Chips +,+,+,-,-,+,- with the first chip in bit 0.
      pat = 7'h27;
      inj_en = 1'b1;
      inj_chip = 1'b0;
      setup(1'b1, 6, BARKER_LEN);
      for (int r = 0; r < 2; r++)
         for (int k = 0; k < 14; k++) begin
            inj_chip = (k < 7) ? pat[k] ^ r[0] : 1'b0;
            repeat (20) @(negedge clk_i);
         end
      repeat (20) @(negedge clk_i);
      cmp("barker_peaks", 8'h02, 8'(peaks.size()));
      foreach (peaks[i]) cmp("barker_sign", 8'(i == 0), 8'(peaks[i]));
      inj_en = 1'b0;
   endtask

   initial begin
      void'($urandom(21));
      repeat (4) @(posedge clk_i);
      @(negedge clk_i);
      sys_rst_i = 1'b0;
      cmp("reset_state", 8'h04, {5'h00, bit_ready_o, tx_active_o, tx_chip_o});
      cmp("reset_result", 8'h00, result_o);
      run_tx(4, 1'b0);
      run_tx(2, 1'b1);
      run_barker();
      wrap_up();
   end

   // The tests take about 5,000 cycles; six times that means a hang.
   initial begin
      #(30000 * CLK_PERIOD_NS);
      failures++;
      wrap_up();
   end
endmodule // tb

`default_nettype wire
